// ==== include/tsa_defs.svh ====
/*
 * Constants of the terminal serial adapter: register indices, status bit
 * positions, reset values and bit timing.
 * Assumes it is included by bare name by the two design files.
 */
`ifndef TSA_DEFS_SVH
`define TSA_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices on the host port
// ----------------------------------------------------------------------
`define TSA_REG_STATUS 1'b0
`define TSA_REG_DATA 1'b1

// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define TSA_ST_RX_FULL 0
`define TSA_ST_TX_EMPTY 1
`define TSA_ST_FRAME_ERR 4
`define TSA_ST_OVERRUN 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TSA_RST_RX_FULL 1'b0
`define TSA_RST_TX_EMPTY 1'b1
`define TSA_RST_TXD 1'b1
`define TSA_RST_BYTE 8'h00

// ----------------------------------------------------------------------
// Timing: timer ticks at the baud rate, receive ticks at 16 times it
// ----------------------------------------------------------------------
`define TSA_BAUD_RATE 4800
`define TSA_TX_FRAME_BITS 4'ha
`define TSA_RX_MID 4'h7
`define TSA_RX_LAST 4'hf
`define TSA_RX_LAST_BIT 3'h7

`endif

// ==== include/tsa_pkg.sv ====
/*
 * Types shared by the terminal serial adapter modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tsa_pkg;

    typedef logic [7:0] byte_t;

    // Transmit sequencer, one-hot
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_t;

    // Receive sequencer, one-hot
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;

    typedef struct packed {
        tx_state_t tx_state;
        logic [9:0] tx_shift;
        logic [3:0] tx_cnt;
        logic tx_pend;
        byte_t tx_hold;
        logic tx_empty;
        logic txd;
        logic rx_full;
        byte_t rx_byte;
        logic frame_err;
        logic overrun;
        byte_t rdata;
    } top_state_t;

    typedef struct packed {
        rx_state_t state;
        logic [3:0] cnt;
        logic [2:0] bitn;
        byte_t shift;
        logic done;
        byte_t data;
        logic frame_err;
    } rx_q_t;

endpackage

// ==== include/rx_link_if.sv ====
/*
 * Carries a finished character from the receive deserializer to the
 * register side.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface rx_link_if;
    logic done;
    tsa_pkg::byte_t data;
    logic frame_err;

    modport producer (output done, output data, output frame_err);
    modport consumer (input done, input data, input frame_err);
endinterface

// ==== rtl/rx_deserializer.sv ====
/*
 * Receive deserializer: finds a start bit, samples eight data bits at mid
 * bit, checks the stop bit and hands the byte over as a one-cycle pulse.
 * Assumes the serial input and the 16x tick are synchronous to the clock.
 */
`timescale 1ns/1ps
`include "tsa_defs.svh"
module rx_deserializer (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_tick16,
    input wire logic rxd,
    rx_link_if.producer link
);
    import tsa_pkg::*;

    rx_q_t state_q;
    rx_q_t state_d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        unique case (state_q.state)
            RX_IDLE: begin
                if (rx_tick16 && !rxd) begin
                    state_d.state = RX_START;
                    state_d.cnt = 4'h0;
                end
            end
            RX_START: begin
                // A glitch shorter than half a bit is dropped here
                if (rx_tick16) begin
                    if (state_q.cnt == `TSA_RX_MID) begin
                        state_d.state = rxd ? RX_IDLE : RX_DATA;
                        state_d.cnt = 4'h0;
                        state_d.bitn = 3'h0;
                    end else begin
                        state_d.cnt = state_q.cnt + 4'h1;
                    end
                end
            end
            RX_DATA: begin
                if (rx_tick16) begin
                    state_d.cnt = state_q.cnt + 4'h1;
                    if (state_q.cnt == `TSA_RX_LAST) begin
                        state_d.shift = {rxd, state_q.shift[7:1]};
                        state_d.bitn = state_q.bitn + 3'h1;
                        if (state_q.bitn == `TSA_RX_LAST_BIT) begin
                            state_d.state = RX_STOP;
                        end
                    end
                end
            end
            RX_STOP: begin
                if (rx_tick16) begin
                    state_d.cnt = state_q.cnt + 4'h1;
                    if (state_q.cnt == `TSA_RX_LAST) begin
                        state_d.done = 1'b1;
                        state_d.data = state_q.shift;
                        state_d.frame_err = ~rxd;
                        state_d.state = RX_IDLE;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '{state: RX_IDLE, cnt: 4'h0, bitn: 3'h0, shift: `TSA_RST_BYTE,
                         done: 1'b0, data: `TSA_RST_BYTE, frame_err: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign link.done = state_q.done;
    assign link.data = state_q.data;
    assign link.frame_err = state_q.frame_err;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_done_from_stop;
        @(posedge clk) disable iff (rst)
        state_q.done |-> $past(state_q.state) == RX_STOP && state_q.state == RX_IDLE;
    endproperty
    a_done_from_stop: assert property (p_done_from_stop)
        else $error("Byte handed over outside the stop bit");

    property p_done_pulse;
        @(posedge clk) disable iff (rst)
        state_q.done |=> !state_q.done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("Byte hand-over lasted more than one cycle");
endmodule

// ==== rtl/terminal_serial_adapter.sv ====
/*
 * Terminal serial adapter: status, receive and transmit byte registers on
 * a small host port, a transmit serializer and the receive deserializer.
 * Assumes timer ticks (baud and 16x baud) and the serial input are
 * synchronous to SYS_CLK, and that software polls the status flags.
 */
// Notes on behaviour
// - Host reads eight-bit status with four flags
// - Complete received character sets receive full
// - Reading receive byte clears receive full
// - Writing transmit byte clears transmit empty
// - Transmit byte serialised one character at once
// - Transmit empty returns high after stop bit
// - Serial bits assembled into byte, loaded
// - Transmit bits timed by 4800 baud timer
// - Receive and transmit paths run independently
`timescale 1ns/1ps
`include "tsa_defs.svh"
module terminal_serial_adapter (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HOST_SEL,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic HOST_ADDR,
    input wire tsa_pkg::byte_t HOST_WDATA,
    output tsa_pkg::byte_t HOST_RDATA,
    input wire logic TX_TICK,
    input wire logic RX_TICK16,
    input wire logic SER_RXD,
    output logic SER_TXD
);
    import tsa_pkg::*;

    top_state_t state_q;
    top_state_t state_d;
    logic rd_status;
    logic rd_data;
    logic wr_data;
    byte_t status_word;

    rx_link_if rx_link ();

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    // separate receive path
    rx_deserializer i_rx_deserializer (
        .clk(SYS_CLK),
        .rst(RST),
        .rx_tick16(RX_TICK16),
        .rxd(SER_RXD),
        .link(rx_link.producer)
    );

    // ------------------------------------------------------------------
    // Host port decode
    // ------------------------------------------------------------------
    assign rd_status = HOST_SEL & HOST_RD & (HOST_ADDR == `TSA_REG_STATUS);
    assign rd_data = HOST_SEL & HOST_RD & (HOST_ADDR == `TSA_REG_DATA);
    assign wr_data = HOST_SEL & HOST_WR & (HOST_ADDR == `TSA_REG_DATA);

    always_comb begin
        status_word = 8'h00;
        status_word[`TSA_ST_RX_FULL] = state_q.rx_full;
        status_word[`TSA_ST_TX_EMPTY] = state_q.tx_empty;
        status_word[`TSA_ST_FRAME_ERR] = state_q.frame_err;
        status_word[`TSA_ST_OVERRUN] = state_q.overrun;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (rd_status) begin
            state_d.rdata = status_word;
        end
        if (rd_data) begin
            state_d.rdata = state_q.rx_byte;
            state_d.rx_full = 1'b0;
            state_d.frame_err = 1'b0;
            state_d.overrun = 1'b0;
        end
        if (rx_link.done) begin
            state_d.rx_byte = rx_link.data;
            state_d.frame_err = rx_link.frame_err;
            state_d.overrun = state_q.rx_full & ~rd_data;
            state_d.rx_full = 1'b1;
        end
        // write clears empty; a write while busy is ignored
        if (wr_data && state_q.tx_empty) begin
            state_d.tx_hold = HOST_WDATA;
            state_d.tx_empty = 1'b0;
            state_d.tx_pend = 1'b1;
        end
        unique case (state_q.tx_state)
            TX_IDLE: begin
                if (TX_TICK && state_q.tx_pend) begin
                    state_d.tx_shift = {1'b1, state_q.tx_hold, 1'b0};
                    state_d.tx_cnt = `TSA_TX_FRAME_BITS;
                    state_d.tx_pend = 1'b0;
                    state_d.tx_state = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (TX_TICK) begin
                    // empty only once the stop bit has run
                    if (state_q.tx_cnt == 4'h0) begin
                        state_d.tx_empty = 1'b1;
                        state_d.tx_state = TX_IDLE;
                    end else begin
                        state_d.txd = state_q.tx_shift[0];
                        state_d.tx_shift = {1'b1, state_q.tx_shift[9:1]};
                        state_d.tx_cnt = state_q.tx_cnt - 4'h1;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // reset values
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= '{tx_state: TX_IDLE, tx_shift: 10'h3ff, tx_cnt: 4'h0,
                         tx_pend: 1'b0, tx_hold: `TSA_RST_BYTE,
                         tx_empty: `TSA_RST_TX_EMPTY, txd: `TSA_RST_TXD,
                         rx_full: `TSA_RST_RX_FULL, rx_byte: `TSA_RST_BYTE,
                         frame_err: 1'b0, overrun: 1'b0, rdata: `TSA_RST_BYTE};
        end else begin
            state_q <= state_d;
        end
    end

    assign HOST_RDATA = state_q.rdata;
    assign SER_TXD = state_q.txd;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_status_read;
        @(posedge SYS_CLK) disable iff (RST)
        rd_status |=> HOST_RDATA[`TSA_ST_RX_FULL] == $past(state_q.rx_full) &&
                      HOST_RDATA[`TSA_ST_TX_EMPTY] == $past(state_q.tx_empty) &&
                      HOST_RDATA[7:6] == 2'b00;
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("Status read does not show the flags");

    property p_full_set;
        @(posedge SYS_CLK) disable iff (RST)
        rx_link.done |=> state_q.rx_full;
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("Receive full not set after a character");

    property p_full_clear;
        @(posedge SYS_CLK) disable iff (RST)
        rd_data && !rx_link.done |=> !state_q.rx_full ##0
            HOST_RDATA == $past(state_q.rx_byte);
    endproperty
    a_full_clear: assert property (p_full_clear)
        else $error("Receive byte read did not clear receive full");

    property p_empty_clear;
        @(posedge SYS_CLK) disable iff (RST)
        wr_data && state_q.tx_empty |=> !state_q.tx_empty && state_q.tx_pend;
    endproperty
    a_empty_clear: assert property (p_empty_clear)
        else $error("Transmit write did not clear transmit empty");

    property p_empty_return;
        @(posedge SYS_CLK) disable iff (RST)
        TX_TICK && state_q.tx_state == TX_SHIFT && state_q.tx_cnt == 4'h0
            |=> state_q.tx_empty && SER_TXD && state_q.tx_state == TX_IDLE;
    endproperty
    a_empty_return: assert property (p_empty_return)
        else $error("Transmit empty not back after the stop bit");

    property p_start_bit;
        @(posedge SYS_CLK) disable iff (RST)
        TX_TICK && state_q.tx_state == TX_SHIFT && state_q.tx_cnt == `TSA_TX_FRAME_BITS
            |=> !SER_TXD;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("Frame did not open with a low start bit");

    property p_tick_timed;
        @(posedge SYS_CLK) disable iff (RST)
        !TX_TICK |=> $stable(SER_TXD);
    endproperty
    a_tick_timed: assert property (p_tick_timed)
        else $error("Serial output moved without a timer tick");

    property p_byte_loaded;
        @(posedge SYS_CLK) disable iff (RST)
        rx_link.done |=> state_q.rx_byte == $past(rx_link.data);
    endproperty
    a_byte_loaded: assert property (p_byte_loaded)
        else $error("Received byte not loaded");

    property p_reset_state;
        @(posedge SYS_CLK) disable iff (RST)
        $fell(RST) |-> SER_TXD && state_q.tx_empty && !state_q.rx_full;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("Wrong flags or line level after reset");
endmodule

// ==== tb/display_terminal_model.sv ====
/*
 * Behavioural operator terminal on the far end of the serial line: sends
 * keyboard characters and decodes display characters at mid bit.
 * Assumes the bench runs the adapter's timer so one bit is BIT_CYCLES clocks.
 */
`timescale 1ns/1ps
module display_terminal_model #(
    parameter int BIT_CYCLES = 32
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    import tsa_pkg::*;

    // --------------------------------------------------------------
    // Keyboard side
    // --------------------------------------------------------------
    byte_t got_q[$];
    logic stop_bad;

    initial begin
        line_out = 1'b1;
        stop_bad = 1'b0;
    end

    // start low, LSB first, stop
    // A low stop value is only used to provoke a framing fault
    task automatic send_frame(input byte_t b, input logic stop_val);
        logic [9:0] frame;
        frame = {stop_val, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= frame[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
        // Idle level between characters; one edge passes so that a following
        // frame never drives the line twice in one time step
        line_out <= 1'b1;
        @(posedge clk);
    endtask

    // --------------------------------------------------------------
    // Display side
    // --------------------------------------------------------------
    // decode at mid bit
    // Samples before the edge's updates land, so reads stay race free
    always begin
        byte_t b;
        @(negedge line_in);
        repeat (BIT_CYCLES / 2) @(posedge clk);
        if (line_in === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk);
                b[i] = line_in;
            end
            repeat (BIT_CYCLES) @(posedge clk);
            if (line_in !== 1'b1) begin
                stop_bad = 1'b1;
            end
            got_q.push_back(b);
        end
    end
endmodule

// ==== tb/terminal_serial_adapter_bench.sv ====
/*
 * Self-checking bench for the terminal serial adapter: host register
 * tasks, a timer model and the terminal model on the serial pins.
 * Assumes the timer is programmed fast (32 clocks a bit) to keep runs short.
 */
`timescale 1ns/1ps
module terminal_serial_adapter_bench;
    import tsa_pkg::*;

    // --------------------------------------------------------------
    // Signals and instances
    // --------------------------------------------------------------
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic HOST_SEL = 1'b0;
    logic HOST_RD = 1'b0;
    logic HOST_WR = 1'b0;
    logic HOST_ADDR = 1'b0;
    byte_t HOST_WDATA = 8'h00;
    byte_t HOST_RDATA;
    logic TX_TICK = 1'b0;
    logic RX_TICK16 = 1'b0;
    logic SER_RXD;
    logic SER_TXD;
    logic [4:0] tick_cnt = 5'h00;
    int failures = 0;
    int n_tests = 0;
    byte_t exp_q[$];
    byte_t s;

    terminal_serial_adapter i_terminal_serial_adapter (.SYS_CLK(SYS_CLK), .RST(RST),
        .HOST_SEL(HOST_SEL), .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_ADDR(HOST_ADDR),
        .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .TX_TICK(TX_TICK),
        .RX_TICK16(RX_TICK16), .SER_RXD(SER_RXD), .SER_TXD(SER_TXD));

    display_terminal_model #(.BIT_CYCLES(32)) i_display_terminal_model (.clk(SYS_CLK),
        .line_in(SER_TXD), .line_out(SER_RXD));

    always #25 SYS_CLK = ~SYS_CLK;

    // timer: 16x tick every 2 clocks, bit tick every 32
    always @(posedge SYS_CLK) begin
        tick_cnt <= tick_cnt + 5'h01;
        RX_TICK16 <= tick_cnt[0];
        TX_TICK <= (tick_cnt == 5'h1f);
    end

    // --------------------------------------------------------------
    // Host tasks
    // --------------------------------------------------------------
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input byte_t exp, input byte_t got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered just after an edge; strobes drop at the take edge
    task automatic host_read(input logic addr, output byte_t d);
        HOST_SEL <= 1'b1;
        HOST_RD <= 1'b1;
        HOST_ADDR <= addr;
        @(posedge SYS_CLK);
        HOST_SEL <= 1'b0;
        HOST_RD <= 1'b0;
        // Registered answer stands from the take edge; taken at the next edge
        @(posedge SYS_CLK);
        d = HOST_RDATA;
    endtask

    task automatic host_write(input byte_t b);
        HOST_SEL <= 1'b1;
        HOST_WR <= 1'b1;
        HOST_ADDR <= 1'b1;
        HOST_WDATA <= b;
        @(posedge SYS_CLK);
        HOST_SEL <= 1'b0;
        HOST_WR <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    // Polls one status bit; a bound that runs out ends the run
    task automatic wait_status(input int pos, input logic val);
        byte_t st;
        int k;
        st = 8'h00;
        for (k = 0; k < 4000; k++) begin
            host_read(1'b0, st);
            if (st[pos] === val) break;
        end
        if (k == 4000) begin
            failures++;
            $display("Error status bit %0d expected %b seen %b", pos, val, st[pos]);
            summarize();
        end
    endtask

    task automatic expect_sent();
        byte_t g;
        g = 8'h00;
        // A missing byte must not pass as a zero byte
        if (i_display_terminal_model.got_q.size() > 0) begin
            g = i_display_terminal_model.got_q.pop_front();
            check("serial byte", exp_q.pop_front(), g);
        end else begin
            n_tests++;
            failures++;
            $display("Error serial byte expected %h seen none", exp_q.pop_front());
        end
    endtask

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (6) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        check("reset line", 8'h01, {7'h00, SER_TXD});
        check("reset rdata", 8'h00, HOST_RDATA);
        host_read(1'b0, s);
        check("reset status", 8'h02, s);
        $display("Test reset done");

        // Back-to-back display bytes, boundary values included
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back(i == 0 ? 8'ha5 : i == 1 ? 8'h00 : i == 2 ? 8'hff : 8'h5a);
            wait_status(1, 1'b1);
            host_write(exp_q[i]);
            host_read(1'b0, s);
            check("status after write", 8'h00, s);
        end
        wait_status(1, 1'b1);
        for (int i = 0; i < 4; i++) expect_sent();
        exp_q.push_back(8'h3c);
        host_write(8'h3c);
        host_write(8'hc3);
        wait_status(1, 1'b1);
        expect_sent();
        check("extra bytes", 8'h00, 8'(i_display_terminal_model.got_q.size()));
        $display("Test transmit done");

        i_display_terminal_model.send_frame(8'h96, 1'b1);
        wait_status(0, 1'b1);
        host_read(1'b0, s);
        check("status full", 8'h03, s);
        host_read(1'b1, s);
        check("receive byte", 8'h96, s);
        host_read(1'b0, s);
        check("status after read", 8'h02, s);
        $display("Test receive done");

        i_display_terminal_model.send_frame(8'h11, 1'b1);
        i_display_terminal_model.send_frame(8'h22, 1'b1);
        repeat (8) @(posedge SYS_CLK);
        host_read(1'b0, s);
        check("status overrun", 8'h23, s);
        host_read(1'b1, s);
        check("newest byte", 8'h22, s);
        i_display_terminal_model.send_frame(8'h77, 1'b0);
        repeat (40) @(posedge SYS_CLK);
        host_read(1'b0, s);
        check("frame error bit", 8'h10, s & 8'h10);
        host_read(1'b1, s);
        check("frame error byte", 8'h77, s);
        host_read(1'b0, s);
        check("status cleared", 8'h02, s);
        $display("Test receive faults done");

        // Both directions at once
        exp_q.push_back(8'he1);
        fork
            i_display_terminal_model.send_frame(8'h4b, 1'b1);
            host_write(8'he1);
        join
        wait_status(0, 1'b1);
        host_read(1'b1, s);
        check("duplex receive", 8'h4b, s);
        wait_status(1, 1'b1);
        expect_sent();
        check("stop bits", 8'h00, {7'h00, i_display_terminal_model.stop_bad});
        $display("Test duplex done");
        summarize();
    end
endmodule
